// File: hw/ipwc_pkg.sv
// constants, field layout and state types shared by both ends of the inverted pair write link
// assumes a 125 MHz system clock on both ends and a 16-bit serial frame
package ipwc_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h11;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic CMD_WRITE = 1'b1;
  localparam logic CMD_READ = 1'b0;
  // frame bit positions, msb first on the wire
  localparam int CMD_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 9;
  localparam int DATA_MSB = 8;
  localparam int DATA_LSB = 1;
  localparam int PAR_POS = 0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 6'h15;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_INV = 6'h16;
  localparam logic [ADDR_W-1:0] ADDR_VOLT = 6'h17;
  localparam logic [ADDR_W-1:0] ADDR_VOLT_INV = 6'h18;
  // control and voltage request fields
  localparam int STATE_MSB = 2;
  localparam int STATE_LSB = 0;
  localparam int STATE_W = 3;
  localparam int RAIL_MSB = 7;
  localparam int RAIL_LSB = 3;
  localparam int RAIL_W = 5;
  localparam int VOUT_MSB = 5;
  localparam int VOUT_LSB = 0;
  localparam int VOUT_W = 6;
  localparam logic [RAIL_W-1:0] RAIL_RST = 5'h00;
  localparam logic [VOUT_W-1:0] VOUT_RST = 6'h00;
  localparam logic [VOUT_W-1:0] VOUT_MAX_DEF = 6'h28;
  // status flag bits
  localparam int FLAG_PAR = 0;
  localparam int FLAG_LEN = 1;
  localparam int FLAG_CTRL = 2;
  localparam int FLAG_VOLT = 3;
  localparam int FLAG_W = 4;
  // link timing
  localparam int SYS_MHZ = 125;
  localparam int T_LEAD_NS = 100;
  localparam int T_LAG_NS = 50;
  localparam int T_TD_NS = 350;
  localparam int T_SPI_PERIOD_NS = 100;
  localparam int TIM_W = 8;
  localparam logic [TIM_W-1:0] LEAD_CYC = TIM_W'((T_LEAD_NS * SYS_MHZ + 999) / 1000);
  localparam logic [TIM_W-1:0] LAG_CYC = TIM_W'((T_LAG_NS * SYS_MHZ + 999) / 1000);
  localparam logic [TIM_W-1:0] TD_CYC = TIM_W'((T_TD_NS * SYS_MHZ + 999) / 1000);
  localparam logic [TIM_W-1:0] HALF_CYC = TIM_W'((T_SPI_PERIOD_NS * SYS_MHZ + 1999) / 2000);
  localparam logic [TIM_W-1:0] TIM_ONE = 8'h01;
  localparam logic [TIM_W-1:0] TIM_ZERO = 8'h00;
  typedef enum logic [1:0] {
    PEND_NONE = 2'b00,
    PEND_CTRL = 2'b01,
    PEND_VOLT = 2'b10
  } ipwc_pend_t;
  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_LEAD = 3'b001,
    HST_SHIFT = 3'b010,
    HST_LAG = 3'b011,
    HST_GAP = 3'b100
  } ipwc_hst_t;
endpackage

// File: hw/ipwc_if.sv
// serial link between the microcontroller end and the checker end
// assumes the testbench instantiates it once and hands each modport to one end
`timescale 1ns/1ns
interface ipwc_if;
  logic spi_clk;
  logic chip_select_pin_n;
  logic sdi;
  logic sdo_out;
  logic sdo_oe_n;
  logic sdo_line;
  logic spi_irq;
  // undriven data output reads high, as the line pull-up would
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_out;
  modport device (
    input spi_clk,
    input chip_select_pin_n,
    input sdi,
    output sdo_out,
    output sdo_oe_n,
    output spi_irq
  );
  modport host (
    output spi_clk,
    output chip_select_pin_n,
    output sdi,
    input sdo_line,
    input spi_irq
  );
endinterface

// File: hw/ipwc_device.sv
// checker end: receives serial write frames and accepts protected requests only as inverted pairs
// assumes the link clock stops outside frames and the master keeps the lead and lag times
`timescale 1ns/1ns
module ipwc_device
  import ipwc_pkg::*;
#(
  parameter logic [VOUT_W-1:0] VOUT_MAX = VOUT_MAX_DEF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  ipwc_if.device link,
  input wire logic [FLAG_W-1:0] status_clear,
  output logic [FLAG_W-1:0] serial_port_status_flags,
  input wire logic [(1<<STATE_W)-1:0] transition_allowed_mask,
  output logic state_request_pulse,
  output logic [STATE_W-1:0] state_request_value,
  output logic rail_config_update,
  output logic [RAIL_W-1:0] rail_config,
  output logic voltage_update,
  output logic [VOUT_W-1:0] output_voltage_field
);
  // link clock domain
  logic [FRAME_BITS-1:0] shift_ff;
  logic [CNT_W-1:0] bit_cnt_ff;
  logic sdo_ff;
  // system domain
  logic cnt_clr_ff;
  logic cs_meta_ff;
  logic cs_sync_ff;
  logic cs_prev_ff;
  ipwc_pend_t pend_ff;
  logic [DATA_W-1:0] pend_data_ff;
  logic [FLAG_W-1:0] flag_ff;
  logic irq_ff;
  logic state_pulse_ff;
  logic [STATE_W-1:0] state_val_ff;
  logic rail_upd_ff;
  logic [RAIL_W-1:0] rail_ff;
  logic volt_upd_ff;
  logic [VOUT_W-1:0] vout_ff;

  // bits captured on the falling link edge; counter held clear between frames
  always_ff @(negedge link.spi_clk) begin
    shift_ff <= {shift_ff[FRAME_BITS-2:0], link.sdi};
  end

  always_ff @(negedge link.spi_clk or posedge cnt_clr_ff) begin
    if (cnt_clr_ff) begin
      bit_cnt_ff <= CNT_ZERO;
      sdo_ff <= 1'b0;
    end else begin
      if (bit_cnt_ff != CNT_MAX) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
      sdo_ff <= link.sdi;
    end
  end

  // write data looped back while selected
  assign link.sdo_out = sdo_ff;
  assign link.sdo_oe_n = link.chip_select_pin_n;

  always_ff @(posedge sys_clk) begin
    cs_meta_ff <= link.chip_select_pin_n;
    cs_sync_ff <= cs_meta_ff;
    cs_prev_ff <= cs_sync_ff;
  end

  // link registers are frozen once chip select is high, so reading them here is safe
  wire frame_end = cs_sync_ff & ~cs_prev_ff;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_clr_ff <= 1'b1;
    end else if (!cs_sync_ff) begin
      cnt_clr_ff <= 1'b0;
    end else if (frame_end) begin
      cnt_clr_ff <= 1'b1;
    end
  end

  wire len_ok = bit_cnt_ff == CNT_FRAME;
  wire par_ok = ~(^shift_ff);
  wire is_write = shift_ff[CMD_POS] == CMD_WRITE;
  wire [ADDR_W-1:0] wr_addr = shift_ff[ADDR_MSB:ADDR_LSB];
  wire [DATA_W-1:0] wr_data = shift_ff[DATA_MSB:DATA_LSB];
  wire wr_ev = frame_end & len_ok & par_ok & is_write;
  wire par_err = frame_end & len_ok & ~par_ok;
  wire len_err = frame_end & ~len_ok;

  wire hit_ctrl = wr_addr == ADDR_CTRL;
  wire hit_ctrl_inv = wr_addr == ADDR_CTRL_INV;
  wire hit_volt = wr_addr == ADDR_VOLT;
  wire hit_volt_inv = wr_addr == ADDR_VOLT_INV;
  wire pend_ctrl = pend_ff == PEND_CTRL;
  wire pend_volt = pend_ff == PEND_VOLT;
  wire [VOUT_W-1:0] wr_vout = wr_data[VOUT_MSB:VOUT_LSB];
  wire [RAIL_W-1:0] req_rail = pend_data_ff[RAIL_MSB:RAIL_LSB];
  wire [VOUT_W-1:0] req_vout = pend_data_ff[VOUT_MSB:VOUT_LSB];
  wire ctrl_inv_ok = wr_data == ~pend_data_ff;
  // voltage pair compares only the output field
  wire volt_inv_ok = wr_vout == ~req_vout;

  // a lone inverse write counts as a broken pair
  wire ctrl_break = pend_ctrl & ~hit_ctrl & ~(hit_ctrl_inv & ctrl_inv_ok);
  wire ctrl_lone = ~pend_ctrl & hit_ctrl_inv;
  wire volt_break = pend_volt & ~hit_volt & ~(hit_volt_inv & volt_inv_ok);
  wire volt_lone = ~pend_volt & hit_volt_inv;
  wire ctrl_ok = wr_ev & pend_ctrl & hit_ctrl_inv & ctrl_inv_ok;
  wire ctrl_err = wr_ev & (ctrl_break | ctrl_lone);
  wire volt_ok = wr_ev & pend_volt & hit_volt_inv & volt_inv_ok;
  wire volt_err = wr_ev & (volt_break | volt_lone);

  wire [STATE_W-1:0] req_state = pend_data_ff[STATE_MSB:STATE_LSB];
  wire state_go = ctrl_ok & transition_allowed_mask[req_state];
  // out-of-range codes are dropped without a flag
  wire vout_in_range = req_vout <= VOUT_MAX;
  wire volt_go = volt_ok & vout_in_range;

  // a first write opens a pair; any other completed write closes it
  wire ipwc_pend_t open_kind = hit_ctrl ? PEND_CTRL : hit_volt ? PEND_VOLT : PEND_NONE;
  wire ipwc_pend_t nxt_pend = wr_ev ? open_kind : pend_ff;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_ff <= PEND_NONE;
      pend_data_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
      if (wr_ev) begin
        pend_data_ff <= wr_data;
      end
    end
  end

  wire [FLAG_W-1:0] flag_set;
  assign flag_set[FLAG_PAR] = par_err;
  assign flag_set[FLAG_LEN] = len_err;
  assign flag_set[FLAG_CTRL] = ctrl_err;
  assign flag_set[FLAG_VOLT] = volt_err;
  wire [FLAG_W-1:0] nxt_flag;

  // a new event wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
      assign nxt_flag[gi] = flag_set[gi] | (flag_ff[gi] & ~status_clear[gi]);
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flag_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      irq_ff <= |nxt_flag;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_pulse_ff <= 1'b0;
      state_val_ff <= '0;
      rail_upd_ff <= 1'b0;
      rail_ff <= RAIL_RST;
      volt_upd_ff <= 1'b0;
      vout_ff <= VOUT_RST;
    end else begin
      state_pulse_ff <= state_go;
      rail_upd_ff <= ctrl_ok;
      volt_upd_ff <= volt_go;
      if (state_go) begin
        state_val_ff <= req_state;
      end
      if (ctrl_ok) begin
        rail_ff <= req_rail;
      end
      if (volt_go) begin
        vout_ff <= req_vout;
      end
    end
  end

  // outputs come straight from registers
  assign link.spi_irq = irq_ff;
  assign serial_port_status_flags = flag_ff;
  assign state_request_pulse = state_pulse_ff;
  assign state_request_value = state_val_ff;
  assign rail_config_update = rail_upd_ff;
  assign rail_config = rail_ff;
  assign voltage_update = volt_upd_ff;
  assign output_voltage_field = vout_ff;
endmodule

// File: hw/ipwc_host.sv
// microcontroller end: turns user commands into serial frames and drives the link clock
// assumes one command at a time; the link clock is divided from sys_clk
`timescale 1ns/1ns
module ipwc_host
  import ipwc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  ipwc_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_data,
  output logic rsp_valid,
  output logic [FRAME_BITS-1:0] rsp_data,
  output logic host_irq
);
  ipwc_hst_t state_ff;
  logic [TIM_W-1:0] tim_ff;
  logic [3:0] bit_ff;
  logic [FRAME_BITS-1:0] tx_ff;
  logic [FRAME_BITS-1:0] rx_ff;
  logic clk_ff;
  logic cs_n_ff;
  logic sdi_ff;
  logic rsp_valid_ff;
  logic [FRAME_BITS-1:0] rsp_ff;
  logic sdo_meta_ff;
  logic sdo_sync_ff;
  logic irq_meta_ff;
  logic irq_sync_ff;

  wire cmd_bit = cmd_write ? CMD_WRITE : CMD_READ;
  wire [FRAME_BITS-2:0] payload = {cmd_bit, cmd_addr, cmd_data};
  wire [FRAME_BITS-1:0] frame = {payload, ^payload};
  wire tim_done = tim_ff == TIM_ZERO;
  wire [3:0] nxt_bit = bit_ff - 4'h1;
  assign cmd_ready = state_ff == HST_IDLE;

  always_ff @(posedge sys_clk) begin
    sdo_meta_ff <= link.sdo_line;
    sdo_sync_ff <= sdo_meta_ff;
    irq_meta_ff <= link.spi_irq;
    irq_sync_ff <= irq_meta_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= HST_IDLE;
      tim_ff <= TIM_ZERO;
      bit_ff <= 4'h0;
      tx_ff <= '0;
      rx_ff <= '0;
      clk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      sdi_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      rsp_valid_ff <= 1'b0;
      if (!tim_done) begin
        tim_ff <= tim_ff - TIM_ONE;
      end
      case (state_ff)
        HST_IDLE: begin
          if (cmd_valid) begin
            tx_ff <= frame;
            cs_n_ff <= 1'b0;
            tim_ff <= LEAD_CYC - TIM_ONE;
            state_ff <= HST_LEAD;
          end
        end
        HST_LEAD: begin
          if (tim_done) begin
            clk_ff <= 1'b1;
            sdi_ff <= tx_ff[FRAME_BITS-1];
            bit_ff <= 4'hf;
            tim_ff <= HALF_CYC - TIM_ONE;
            state_ff <= HST_SHIFT;
          end
        end
        HST_SHIFT: begin
          if (tim_done) begin
            tim_ff <= HALF_CYC - TIM_ONE;
            clk_ff <= ~clk_ff;
            if (clk_ff) begin
              rx_ff <= {rx_ff[FRAME_BITS-2:0], sdo_sync_ff};
              if (bit_ff == 4'h0) begin
                tim_ff <= LAG_CYC - TIM_ONE;
                state_ff <= HST_LAG;
              end
            end else begin
              sdi_ff <= tx_ff[nxt_bit];
              bit_ff <= nxt_bit;
            end
          end
        end
        HST_LAG: begin
          if (tim_done) begin
            cs_n_ff <= 1'b1;
            rsp_valid_ff <= 1'b1;
            rsp_ff <= rx_ff;
            tim_ff <= TD_CYC - TIM_ONE;
            state_ff <= HST_GAP;
          end
        end
        HST_GAP: begin
          if (tim_done) begin
            state_ff <= HST_IDLE;
          end
        end
        default: begin
          state_ff <= HST_IDLE;
        end
      endcase
    end
  end

  assign link.spi_clk = clk_ff;
  assign link.chip_select_pin_n = cs_n_ff;
  assign link.sdi = sdi_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_ff;
  assign host_irq = irq_sync_ff;
endmodule

// File: tb/ipwc_chk.sv
// checker for the serial link between the two ends of the inverted pair write link
// assumes one sys_clk for both ends and the link signals handed in as plain inputs
`timescale 1ns/1ns
module ipwc_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic chip_select_pin_n,
  input wire logic sdi,
  input wire logic sdo_oe_n,
  input wire logic sdo_line,
  input wire logic spi_irq
);
  logic [4:0] rise_ff;
  logic clk_d_ff;
  wire rise_ev = spi_clk && !clk_d_ff;
  wire cnt_clr = sys_rst || chip_select_pin_n;
  always_ff @(posedge sys_clk) begin
    clk_d_ff <= spi_clk;
    rise_ff <= cnt_clr ? 5'h00 : rise_ff + {4'h0, rise_ev};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_oe; sdo_oe_n == chip_select_pin_n; endproperty
  a_oe: assert property (p_oe) else $error("sdo enable differs from select");
  property p_idle; chip_select_pin_n |-> !spi_clk; endproperty
  a_idle: assert property (p_idle) else $error("link clock runs outside frame");
  property p_pull; sdo_oe_n |-> sdo_line; endproperty
  a_pull: assert property (p_pull) else $error("released data line not high");
  property p_lead; $fell(chip_select_pin_n) |-> !spi_clk [*8]; endproperty
  a_lead: assert property (p_lead) else $error("lead time too short");
  property p_sdi; spi_clk && $past(spi_clk) |-> $stable(sdi); endproperty
  a_sdi: assert property (p_sdi) else $error("data moved while clock high");
  property p_count; $rose(chip_select_pin_n) |-> rise_ff == 5'h10; endproperty
  a_count: assert property (p_count) else $error("frame clock count not sixteen");
  property p_irq; $rose(spi_irq) |-> chip_select_pin_n && $past(chip_select_pin_n); endproperty
  a_irq: assert property (p_irq) else $error("interrupt raised inside frame");
  property p_lag; $fell(spi_clk) |-> !chip_select_pin_n [*4]; endproperty
  a_lag: assert property (p_lag) else $error("lag time too short");
  property p_gap; $rose(chip_select_pin_n) |-> chip_select_pin_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("frame gap too short");
  c_frame: cover property ($rose(chip_select_pin_n));
  c_irq: cover property ($rose(spi_irq));
  c_clr: cover property ($fell(spi_irq));
endmodule

// File: tb/tb_top.sv
// self-checking bench: host end drives frames into the device end, a model predicts results
// assumes both ends on one sys_clk; the host divides the link clock itself
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  import ipwc_pkg::*;
  logic sys_clk, sys_rst, cmd_valid, cmd_ready, cmd_write, rsp_valid, host_irq, st_p, rail_u, volt_u;
  logic [5:0] cmd_addr, volt, m_volt, a;
  logic [7:0] cmd_data, mask, pd, d, e;
  logic [15:0] rsp_data;
  logic [3:0] status_clear, flags, m_flags;
  logic [2:0] st_v, m_st;
  logic [4:0] rail, m_rail;
  int fails, tests_run, n_st, n_rail, n_volt, m_nst, m_nrail, m_nvolt;
  ipwc_pend_t pend;
  ipwc_if ipwc_if_i ();
  ipwc_host ipwc_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(ipwc_if_i.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .host_irq(host_irq));
  ipwc_device ipwc_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(ipwc_if_i.device),
    .status_clear(status_clear), .serial_port_status_flags(flags), .transition_allowed_mask(mask),
    .state_request_pulse(st_p), .state_request_value(st_v), .rail_config_update(rail_u), .rail_config(rail),
    .voltage_update(volt_u), .output_voltage_field(volt));
  ipwc_chk ipwc_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_clk(ipwc_if_i.spi_clk),
    .chip_select_pin_n(ipwc_if_i.chip_select_pin_n), .sdi(ipwc_if_i.sdi), .sdo_oe_n(ipwc_if_i.sdo_oe_n),
    .sdo_line(ipwc_if_i.sdo_line), .spi_irq(ipwc_if_i.spi_irq));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    n_st += (st_p === 1'b1);
    n_rail += (rail_u === 1'b1);
    n_volt += (volt_u === 1'b1);
  end
  task results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_on(input bit rsp);
    int k;
    k = 0;
    while ((rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
      if (k == 2000) begin
        fails++;
        results();
      end
      @(posedge sys_clk);
      #1 k++;
    end
  endtask
  task automatic model(input logic w, input logic [5:0] a, input logic [7:0] d);
    logic [5:0] pa;
    pa = (pend == PEND_CTRL) ? ADDR_CTRL : ADDR_VOLT;
    if (!w) return;
    if (pend != PEND_NONE && a != pa && a != pa + 6'h01) begin
      m_flags[(pend == PEND_CTRL) ? FLAG_CTRL : FLAG_VOLT] = 1'b1;
      pend = PEND_NONE;
    end
    case (a)
      ADDR_CTRL, ADDR_VOLT: begin
        pend = (a == ADDR_CTRL) ? PEND_CTRL : PEND_VOLT;
        pd = d;
      end
      ADDR_CTRL_INV: begin
        if (pend == PEND_CTRL && d == ~pd) begin
          m_rail = pd[RAIL_MSB:RAIL_LSB];
          m_nrail++;
          if (mask[pd[STATE_MSB:STATE_LSB]]) begin
            m_st = pd[STATE_MSB:STATE_LSB];
            m_nst++;
          end
        end else m_flags[FLAG_CTRL] = 1'b1;
        pend = PEND_NONE;
      end
      ADDR_VOLT_INV: begin
        if (pend == PEND_VOLT && d[5:0] == ~pd[5:0]) begin
          if (pd[5:0] <= VOUT_MAX_DEF) begin
            m_volt = pd[5:0];
            m_nvolt++;
          end
        end else m_flags[FLAG_VOLT] = 1'b1;
        pend = PEND_NONE;
      end
      default: ;
    endcase
  endtask
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {w, a, d, 1'b0};
    f[0] = ^f[15:1];
    wait_on(0);
    {cmd_valid, cmd_write, cmd_addr, cmd_data} = {1'b1, w, a, d};
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    wait_on(1);
    if (w) `CHK("loopback", {1'b0, f[15:1]}, rsp_data)
    model(w, a, d);
    wait_on(0);
    `CHK("flags", m_flags, flags)
    `CHK("irq", |m_flags, ipwc_if_i.spi_irq)
    `CHK("host irq", |m_flags, host_irq)
    `CHK("rail", m_rail, rail)
    `CHK("state", m_st, st_v)
    `CHK("volt", m_volt, volt)
    `CHK("pulses", {m_nst, m_nrail, m_nvolt}, {n_st, n_rail, n_volt})
    if (m_flags != 4'h0) begin
      status_clear = 4'hf;
      @(posedge sys_clk);
      #1 status_clear = 4'h0;
      m_flags = 4'h0;
    end
  endtask
  task automatic pair(input logic [5:0] a, input logic [7:0] d, input logic [7:0] di, input string s);
    xfer(1'b1, a, d);
    xfer(1'b1, a + 6'h01, di);
    $display("test %0s done", s);
  endtask
  initial begin
    {sys_rst, cmd_valid, cmd_write, cmd_addr, cmd_data, status_clear, mask} = {1'b1, 20'h0, 8'hff};
    {fails, tests_run, n_st, n_rail, n_volt, m_nst, m_nrail, m_nvolt} = '0;
    {m_flags, m_st, m_rail, m_volt, pd} = '0;
    pend = PEND_NONE;
    void'($urandom(10417));
    repeat (4) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    pair(ADDR_CTRL, 8'h2b, 8'hd4, "ctrl pair");
    mask = 8'h00;
    pair(ADDR_CTRL, 8'h55, 8'haa, "forbidden state");
    mask = 8'hff;
    pair(ADDR_CTRL, 8'h33, 8'hcd, "not inverse");
    xfer(1'b1, ADDR_CTRL, 8'h12);
    xfer(1'b1, 6'h01, 8'h00);
    pair(ADDR_CTRL_INV, 8'hed, 8'h00, "intrusion");
    xfer(1'b1, ADDR_CTRL, 8'h12);
    xfer(1'b0, ADDR_VOLT, 8'h00);
    xfer(1'b1, ADDR_CTRL_INV, 8'hed);
    pair(ADDR_VOLT, 8'hd0, 8'hef, "volt pair");
    pair(ADDR_VOLT, 8'h3f, 8'h00, "volt out of range");
    pair(ADDR_VOLT, 8'h05, 8'hfb, "volt not inverse");
    xfer(1'b1, ADDR_VOLT, 8'h11);
    pair(ADDR_CTRL, 8'h0c, 8'hf3, "volt intrusion");
    repeat (16) begin
      a = $urandom_range(1) ? ADDR_CTRL : ADDR_VOLT;
      d = 8'($urandom);
      mask = 8'($urandom);
      e = ($urandom_range(3) == 0) ? 8'h01 << $urandom_range(7) : 8'h00;
      pair(a, d, ~d ^ e, "random pair");
    end
    results();
  end
endmodule
